// [src/cpc_pkg.sv]
// Package for the copper line control and gigabit capability register block.
// Assumes a single 250 MHz clock and an AXI4-Lite register slave.
package cpc_pkg;

  // ==========================================================================
  // Register map: 0xf and 0x10 are word indices, byte address is four times the index
  localparam int unsigned CPC_ADDR_W = 8;
  localparam logic [4:0] CPC_IDX_CAP = 5'h0f;
  localparam logic [4:0] CPC_IDX_CTL = 5'h10;
  localparam logic [4:0] CPC_IDX_STAT = 5'h11;
  localparam logic [4:0] CPC_IDX_MISC = 5'h12;
  localparam logic [CPC_ADDR_W-1:0] CPC_ADDR_CAP = {1'b0, CPC_IDX_CAP, 2'b00};
  localparam logic [CPC_ADDR_W-1:0] CPC_ADDR_CTL = {1'b0, CPC_IDX_CTL, 2'b00};
  localparam logic [CPC_ADDR_W-1:0] CPC_ADDR_STAT = {1'b0, CPC_IDX_STAT, 2'b00};
  localparam logic [CPC_ADDR_W-1:0] CPC_ADDR_MISC = {1'b0, CPC_IDX_MISC, 2'b00};

  // ==========================================================================
  // Gigabit capability word
  localparam logic [15:0] CPC_CAP_VALUE = 16'h3000;

  // ==========================================================================
  // Copper line control fields
  localparam int unsigned CPC_B_LP_DIS = 15;
  localparam int unsigned CPC_B_RSV_HI = 12;
  localparam int unsigned CPC_B_RSV_11 = 11;
  localparam int unsigned CPC_B_FORCE = 10;
  localparam int unsigned CPC_B_ED = 8;
  localparam int unsigned CPC_B_RSV_7 = 7;
  localparam int unsigned CPC_B_XO = 5;
  localparam int unsigned CPC_B_RSV_4 = 4;
  localparam int unsigned CPC_B_TX_DIS = 3;
  localparam int unsigned CPC_B_PD = 2;
  localparam int unsigned CPC_B_POL_DIS = 1;
  localparam int unsigned CPC_B_JAB_DIS = 0;
  localparam logic [15:0] CPC_CTL_RESET = 16'h3060;
  // Bits that a software reset returns to their hardware reset value
  localparam logic [15:0] CPC_CTL_SWRST_MASK = 16'hf000;
  // Writable bits (bit 7 reserved, not implemented)
  localparam logic [15:0] CPC_CTL_WMASK = 16'hff7f;

  // ==========================================================================
  // Own misc register: basic control bits
  localparam int unsigned CPC_M_SWRST = 0;
  localparam int unsigned CPC_M_RESTART = 1;
  localparam int unsigned CPC_M_PD = 2;

  // ==========================================================================
  // Status register bits
  localparam int unsigned CPC_S_LINK = 0;
  localparam int unsigned CPC_S_POL = 1;
  localparam int unsigned CPC_S_PAIR = 4;
  localparam int unsigned CPC_S_PD = 8;
  localparam int unsigned CPC_S_XO = 9;

  localparam logic [1:0] CPC_RESP_OKAY = 2'b00;
  localparam logic [1:0] CPC_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CPC_XO_STRAIGHT,
    CPC_XO_CROSSED,
    CPC_XO_RSVD,
    CPC_XO_AUTO
  } cpc_xo_type;

  typedef enum logic [1:0] {
    CPC_ED_OFF,
    CPC_ED_SENSE,
    CPC_ED_SENSE_PULSE
  } cpc_ed_type;

endpackage

// [src/cpc_line_decode.sv]
// Decodes the latched copper control word into line control levels.
// Assumes inputs from the register bank and link status from the PHY core.
`timescale 1ns/10ps
module cpc_line_decode (
  input wire logic [15:0] ctl,
  input wire logic [1:0] xo_active,
  input wire logic mode_gig,
  input wire logic mode_10_hdx,
  input wire logic link_fsm_up,
  input wire logic pol_raw,
  input wire logic powered_down,
  output logic link_pulse_en,
  output logic link_up,
  output cpc_pkg::cpc_ed_type ed_mode,
  output logic xo_auto,
  output logic xo_crossed,
  output logic tx_en,
  output logic pol_rev,
  output logic jabber_en
);
  import cpc_pkg::*;

  always_comb begin
    link_pulse_en = !ctl[CPC_B_LP_DIS] && !powered_down;
    link_up = (ctl[CPC_B_FORCE] && !mode_gig) || link_fsm_up;
    unique case (ctl[CPC_B_ED+1 -: 2])
      2'b10: ed_mode = CPC_ED_SENSE;
      2'b11: ed_mode = CPC_ED_SENSE_PULSE;
      default: ed_mode = CPC_ED_OFF;
    endcase
    xo_auto = (xo_active == 2'(CPC_XO_AUTO));
    xo_crossed = (xo_active == 2'(CPC_XO_CROSSED));
    tx_en = !ctl[CPC_B_TX_DIS] && !powered_down;
    // Correction off forces normal polarity whenever mode_gig is low
    pol_rev = pol_raw && !(ctl[CPC_B_POL_DIS] && !mode_gig);
    jabber_en = !ctl[CPC_B_JAB_DIS] && mode_10_hdx;
  end
endmodule

// [src/cpc_regs.sv]
// Gigabit capability and copper line control register bank, AXI4-Lite slave.
// Assumes one clock (aclk), synchronous active-low reset and PHY core status.
`timescale 1ns/10ps
// What this block does
// - Capability bits 15 and 14 always read 0: no 1000BASE-X ability.
// - Capability bits 13 and 12 always read 1: 1000BASE-T full and half.
// - Control bit 15 stops link pulses; both resets clear it.
// - Bit 10 forces link up, except in 1000BASE-T where it does nothing.
// - Field 9:8: 0x off, 10 sense only, 11 sense plus idle pulses.
// - Field 6:5: 00 straight, 01 crossed, 10 reserved, 11 automatic; resets to 3.
// - New crossover value takes effect only at a software reset.
// - Bit 3 disables the transmitter; software reset keeps it.
// - Powered down while either basic or copper power-down bit is set.
// - Leaving power down performs software reset and negotiation restart.
// - Bit 1 disables polarity correction, forcing normal polarity in 10BASE-T.
// - Polarity shows in status bit 1, per pair in gigabit mode.
// - Bit 0 disables jabber, which applies only in 10BASE-T half duplex.
module cpc_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpc_pkg::CPC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cpc_pkg::CPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_gig,
  input wire logic mode_10_hdx,
  input wire logic link_fsm_up,
  input wire logic pol_raw,
  input wire logic [3:0] pair_pol,
  output logic link_pulse_en,
  output logic link_up,
  output cpc_pkg::cpc_ed_type ed_mode,
  output logic xo_auto,
  output logic xo_crossed,
  output logic tx_en,
  output logic pol_rev,
  output logic jabber_en,
  output logic power_down,
  output logic soft_reset_pulse,
  output logic an_restart_pulse
);
  import cpc_pkg::*;

  // ==========================================================================
  // State
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  // Ready lines are registered inverses of the next hold state (arready of rvalid) so that every port leaves a flop
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic arready_r, arready_nxt;
  logic [CPC_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] ctl_r, ctl_nxt;
  logic [1:0] xo_active_r, xo_active_nxt;
  logic basic_pd_r, basic_pd_nxt;
  logic pd_r, pd_nxt;
  logic swrst_r, swrst_nxt;
  logic restart_r, restart_nxt;
  logic [15:0] status_r, status_nxt;
  logic link_pulse_en_r, link_up_r, xo_auto_r, xo_crossed_r, tx_en_r, pol_rev_r, jabber_en_r;
  cpc_ed_type ed_mode_r;

  logic link_pulse_en_c, link_up_c, xo_auto_c, xo_crossed_c, tx_en_c, pol_rev_c, jabber_en_c;
  cpc_ed_type ed_mode_c;
  logic wr_fire, rd_fire, pd_now, soft_rst_now;

  // Merge a 32-bit write with byte strobes onto a 16-bit register
  function automatic logic [15:0] cpc_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic cpc_mapped(input logic [CPC_ADDR_W-1:0] a);
    return (a == CPC_ADDR_CAP) || (a == CPC_ADDR_CTL) || (a == CPC_ADDR_STAT) || (a == CPC_ADDR_MISC);
  endfunction

  cpc_line_decode i_cpc_line_decode (
    .ctl(ctl_r),
    .xo_active(xo_active_r),
    .mode_gig(mode_gig),
    .mode_10_hdx(mode_10_hdx),
    .link_fsm_up(link_fsm_up),
    .pol_raw(pol_raw),
    .powered_down(pd_r),
    .link_pulse_en(link_pulse_en_c),
    .link_up(link_up_c),
    .ed_mode(ed_mode_c),
    .xo_auto(xo_auto_c),
    .xo_crossed(xo_crossed_c),
    .tx_en(tx_en_c),
    .pol_rev(pol_rev_c),
    .jabber_en(jabber_en_c)
  );

  // ==========================================================================
  // Bus and register next state
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctl_nxt = ctl_r;
    xo_active_nxt = xo_active_r;
    basic_pd_nxt = basic_pd_r;
    swrst_nxt = 1'b0;
    restart_nxt = 1'b0;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    soft_rst_now = 1'b0;
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = cpc_mapped(awaddr_r) ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
      if (awaddr_r == CPC_ADDR_CTL) begin
        // Reserved bits other than bit 7 are stored as written; software keeps them at reset value
        ctl_nxt = (cpc_merge(ctl_r, wdata_r, wstrb_r) & CPC_CTL_WMASK);
      end
      if (awaddr_r == CPC_ADDR_MISC) begin
        if (wstrb_r[0]) begin
          basic_pd_nxt = wdata_r[CPC_M_PD];
          soft_rst_now = wdata_r[CPC_M_SWRST];
          restart_nxt = wdata_r[CPC_M_RESTART];
        end
      end
      // Capability and status writes are ignored
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end

    pd_now = ctl_nxt[CPC_B_PD] || basic_pd_nxt;
    pd_nxt = pd_now;
    // Power-up performs a software reset and negotiation restart
    if (pd_r && !pd_now) begin
      soft_rst_now = 1'b1;
      restart_nxt = 1'b1;
    end
    if (soft_rst_now) begin
      swrst_nxt = 1'b1;
      // Bits 15:12 (link pulse disable and upper reserved bits) return to reset values; others kept
      ctl_nxt = (ctl_nxt & ~CPC_CTL_SWRST_MASK) | (CPC_CTL_RESET & CPC_CTL_SWRST_MASK);
      xo_active_nxt = ctl_nxt[CPC_B_XO+1 -: 2];
    end

    rd_fire = s_axi_arvalid && !rvalid_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = cpc_mapped(s_axi_araddr) ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
      unique case (s_axi_araddr)
        CPC_ADDR_CAP: rdata_nxt = {16'h0000, CPC_CAP_VALUE};
        CPC_ADDR_CTL: rdata_nxt = {16'h0000, ctl_r};
        CPC_ADDR_STAT: rdata_nxt = {16'h0000, status_r};
        CPC_ADDR_MISC: rdata_nxt = {29'h0, basic_pd_r, 2'b00};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // A channel is ready again only once its held item has been consumed
    awready_nxt = !aw_hold_nxt;
    wready_nxt = !w_hold_nxt;
    arready_nxt = !rvalid_nxt;

    // Polarity: single bit normally, per pair in gigabit mode
    status_nxt = 16'h0000;
    status_nxt[CPC_S_LINK] = link_up_r;
    status_nxt[CPC_S_POL] = mode_gig ? 1'b0 : pol_rev_r;
    status_nxt[CPC_S_PAIR +: 4] = mode_gig ? pair_pol : 4'h0;
    status_nxt[CPC_S_PD] = pd_r;
    status_nxt[CPC_S_XO +: 2] = xo_active_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= CPC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= CPC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      ctl_r <= CPC_CTL_RESET;
      xo_active_r <= CPC_CTL_RESET[CPC_B_XO+1 -: 2];
      basic_pd_r <= 1'b0;
      pd_r <= 1'b0;
      swrst_r <= 1'b0;
      restart_r <= 1'b0;
      status_r <= 16'h0000;
      link_pulse_en_r <= 1'b0;
      link_up_r <= 1'b0;
      ed_mode_r <= CPC_ED_OFF;
      xo_auto_r <= 1'b0;
      xo_crossed_r <= 1'b0;
      tx_en_r <= 1'b0;
      pol_rev_r <= 1'b0;
      jabber_en_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctl_r <= ctl_nxt;
      xo_active_r <= xo_active_nxt;
      basic_pd_r <= basic_pd_nxt;
      pd_r <= pd_nxt;
      swrst_r <= swrst_nxt;
      restart_r <= restart_nxt;
      status_r <= status_nxt;
      link_pulse_en_r <= link_pulse_en_c;
      link_up_r <= link_up_c;
      ed_mode_r <= ed_mode_c;
      xo_auto_r <= xo_auto_c;
      xo_crossed_r <= xo_crossed_c;
      tx_en_r <= tx_en_c;
      pol_rev_r <= pol_rev_c;
      jabber_en_r <= jabber_en_c;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign link_pulse_en = link_pulse_en_r;
  assign link_up = link_up_r;
  assign ed_mode = ed_mode_r;
  assign xo_auto = xo_auto_r;
  assign xo_crossed = xo_crossed_r;
  assign tx_en = tx_en_r;
  assign pol_rev = pol_rev_r;
  assign jabber_en = jabber_en_r;
  assign power_down = pd_r;
  assign soft_reset_pulse = swrst_r;
  assign an_restart_pulse = restart_r;

endmodule

// [testbench/cpc_regs_props.sv]
// Concurrent checks on the copper control register block.
// Sees only top-level ports; bound from the bench top file.
`timescale 1ns/10ps
module cpc_regs_props
  import cpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpc_pkg::CPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic mode_gig,
  input wire logic mode_10_hdx,
  input wire logic link_fsm_up,
  input wire logic pol_raw,
  input wire logic link_pulse_en,
  input wire logic link_up,
  input wire logic tx_en,
  input wire logic pol_rev,
  input wire logic jabber_en,
  input wire logic power_down,
  input wire logic soft_reset_pulse,
  input wire logic an_restart_pulse
);
  logic cap_rd;
  assign cap_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == CPC_ADDR_CAP);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Capability word
  property p_cap_zero; cap_rd |=> s_axi_rvalid && s_axi_rdata[15:14] == 2'h0; endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("capability bits 15:14 not zero");
  property p_cap_one; cap_rd |=> s_axi_rvalid && s_axi_rdata[13:12] == 2'h3; endproperty
  a_cap_one: assert property (p_cap_one) else $error("capability bits 13:12 not set");
  property p_cap_rsv; cap_rd |=> s_axi_rdata[11:0] == 12'h000 && s_axi_rdata[31:16] == 16'h0000; endproperty
  a_cap_rsv: assert property (p_cap_rsv) else $error("capability reserved bits not zero");
  // ==========================================================================
  // Power down and line controls
  property p_pd_quiet; power_down [*3] |-> !tx_en && !link_pulse_en; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("line active while powered down");
  property p_pd_exit; $fell(power_down) |-> ##[0:3] soft_reset_pulse; endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("no soft reset on power up");
  property p_pd_restart; $fell(power_down) |-> ##[0:4] an_restart_pulse; endproperty
  a_pd_restart: assert property (p_pd_restart) else $error("no negotiation restart on power up");
  property p_gig_nolink; mode_gig && !link_fsm_up |=> !link_up; endproperty
  a_gig_nolink: assert property (p_gig_nolink) else $error("link forced up in gigabit mode");
  property p_pol_off; !pol_raw |=> !pol_rev; endproperty
  a_pol_off: assert property (p_pol_off) else $error("reversed polarity without detection");
  property p_jab; !mode_10_hdx |=> !jabber_en; endproperty
  a_jab: assert property (p_jab) else $error("jabber active outside 10M half duplex");
endmodule

// [testbench/copper_phy_ctrl_ext_status_bench.sv]
// Self-checking bench for the copper control register block.
// Assumes cpc_pkg, cpc_regs and cpc_regs_props are compiled first.
`timescale 1ns/10ps
module copper_phy_ctrl_ext_status_bench;
  import cpc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, inp = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lp_en, lnk, xa, xc, tx, pr, jb, pd, srp, arp;
  logic [1:0] bresp, rresp, x, prev;
  cpc_ed_type ed;
  int errors = 0, n_checks = 0, sr_cnt = 0, an_cnt = 0, s, a, i;
  cpc_regs i_cpc_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mode_gig(inp[7]), .mode_10_hdx(inp[6]), .link_fsm_up(inp[5]),
    .pol_raw(inp[4]), .pair_pol(inp[3:0]), .link_pulse_en(lp_en), .link_up(lnk), .ed_mode(ed),
    .xo_auto(xa), .xo_crossed(xc), .tx_en(tx), .pol_rev(pr), .jabber_en(jb), .power_down(pd),
    .soft_reset_pulse(srp), .an_restart_pulse(arp)
  );
  initial begin
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (srp === 1'b1) sr_cnt++;
    if (arp === 1'b1) an_cnt++;
  end
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================================================
  // AXI4-Lite master cycles and input drive
  task automatic wr(input logic [7:0] ad, input logic [31:0] dv, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] dv);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dv = rdata;
    rready <= 1'b0;
    chk(rresp, er);
  endtask
  // Input byte: mode_gig, mode_10_hdx, link_fsm_up, pol_raw, pair_pol
  task automatic drv(input logic [7:0] v);
    @(posedge aclk);
    inp <= v;
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, errors);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("ERROR %0t: run did not finish in time", $time);
    print_verdict;
  end
  // ==========================================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CPC_ADDR_CAP, CPC_RESP_OKAY, d);
    chk(d, 32'h3000);
    rd(CPC_ADDR_CTL, CPC_RESP_OKAY, d);
    chk(d, 32'h3060);
    settle;
    chk({xa, xc, lp_en, tx}, 4'b1011);
    done("reset");
    wr(CPC_ADDR_CAP, 32'hffff, CPC_RESP_OKAY);
    rd(CPC_ADDR_CAP, CPC_RESP_OKAY, d);
    chk(d, 32'h3000);
    wr(8'h80, 32'h1, CPC_RESP_SLVERR);
    rd(8'h80, CPC_RESP_SLVERR, d);
    chk(d, 32'h0);
    done("access");
    drv(8'h50);
    for (i = 0; i < 4; i++) begin
      x = i[1:0];
      wr(CPC_ADDR_CTL, 32'h3060 | {x, 8'h00}, CPC_RESP_OKAY);
      settle;
      chk(ed, !x[1] ? CPC_ED_OFF : (x[0] ? CPC_ED_SENSE_PULSE : CPC_ED_SENSE));
    end
    wr(CPC_ADDR_CTL, 32'hb76b, CPC_RESP_OKAY);
    rd(CPC_ADDR_CTL, CPC_RESP_OKAY, d);
    chk(d, 32'hb76b);
    settle;
    chk({lp_en, tx, lnk, pr, jb}, 5'b00100);
    drv(8'hd0);
    settle;
    chk({lnk, pr}, 2'b01);
    wr(CPC_ADDR_CTL, 32'h3060, CPC_RESP_OKAY);
    drv(8'h50);
    settle;
    chk({lp_en, tx, lnk, pr, jb}, 5'b11011);
    done("controls");
    prev = 2'b10;
    for (i = 0; i < 4; i++) begin
      x = i[1:0];
      wr(CPC_ADDR_CTL, 32'hb008 | {x, 5'h00}, CPC_RESP_OKAY);
      settle;
      chk({xa, xc}, prev);
      wr(CPC_ADDR_MISC, 32'h1, CPC_RESP_OKAY);
      settle;
      prev = {x == 2'b11, x == 2'b01};
      chk({xa, xc}, prev);
      rd(CPC_ADDR_CTL, CPC_RESP_OKAY, d);
      chk(d, 32'h3008 | {x, 5'h00});
    end
    wr(CPC_ADDR_CTL, 32'hb00b, CPC_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CPC_ADDR_CTL, CPC_RESP_OKAY, d);
    chk(d, 32'h3060);
    settle;
    chk({xa, xc, lp_en, tx}, 4'b1011);
    wr(CPC_ADDR_CTL, 32'h3060, CPC_RESP_OKAY);
    done("crossover");
    s = sr_cnt;
    a = an_cnt;
    wr(CPC_ADDR_MISC, 32'h4, CPC_RESP_OKAY);
    rd(CPC_ADDR_MISC, CPC_RESP_OKAY, d);
    chk(d, 32'h4);
    settle;
    chk({pd, tx, lp_en}, 3'b100);
    wr(CPC_ADDR_CTL, 32'h3064, CPC_RESP_OKAY);
    wr(CPC_ADDR_MISC, 32'h0, CPC_RESP_OKAY);
    settle;
    chk({pd, tx}, 2'b10);
    chk(sr_cnt - s, 0);
    wr(CPC_ADDR_CTL, 32'h3060, CPC_RESP_OKAY);
    settle;
    chk({pd, tx}, 2'b01);
    chk(sr_cnt - s, 1);
    chk(an_cnt - a, 1);
    done("power");
    s = sr_cnt;
    a = an_cnt;
    wr(CPC_ADDR_MISC, 32'h2, CPC_RESP_OKAY);
    settle;
    chk(an_cnt - a, 1);
    chk(sr_cnt - s, 0);
    rd(CPC_ADDR_MISC, CPC_RESP_OKAY, d);
    chk(d, 32'h0);
    done("restart");
    drv(8'h5a);
    settle;
    rd(CPC_ADDR_STAT, CPC_RESP_OKAY, d);
    chk(d[1], 1'b1);
    chk({d[10:8], d[0]}, 4'b1100);
    drv(8'hda);
    settle;
    rd(CPC_ADDR_STAT, CPC_RESP_OKAY, d);
    chk({d[7:4], d[1]}, 5'b10100);
    done("polarity");
    print_verdict;
  end
endmodule
bind cpc_regs cpc_regs_props i_cpc_regs_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .mode_gig(mode_gig), .mode_10_hdx(mode_10_hdx), .link_fsm_up(link_fsm_up), .pol_raw(pol_raw),
  .link_pulse_en(link_pulse_en), .link_up(link_up), .tx_en(tx_en), .pol_rev(pol_rev),
  .jabber_en(jabber_en), .power_down(power_down), .soft_reset_pulse(soft_reset_pulse),
  .an_restart_pulse(an_restart_pulse)
);
